// file: rtl/tpw_pkg.sv
// Purpose: Constants and carrier types for the timer based pulse unit
// Assumes: APB slave, 32-bit data, byte addresses in the low 8 bits
// Notes:   Single-register and range-end offsets, field positions and reset values are named here once
package tpw_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NMR  = 7;
  localparam int NCAP = 4;
  localparam int NEM  = 4;
  localparam int NPWM = 6;

  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] A_IR  = 8'h00;
  localparam logic [7:0] A_TCR = 8'h04;
  localparam logic [7:0] A_TC  = 8'h08;
  localparam logic [7:0] A_PR  = 8'h0C;
  localparam logic [7:0] A_PC  = 8'h10;
  localparam logic [7:0] A_MCR = 8'h14;
  localparam logic [7:0] A_MR0 = 8'h18;
  localparam logic [7:0] A_MR3 = 8'h24;
  localparam logic [7:0] A_CCR = 8'h28;
  localparam logic [7:0] A_CR0 = 8'h2C;
  localparam logic [7:0] A_CR3 = 8'h38;
  localparam logic [7:0] A_EMR = 8'h3C;
  localparam logic [7:0] A_MR4 = 8'h40;
  localparam logic [7:0] A_MR6 = 8'h48;
  localparam logic [7:0] A_PCR = 8'h4C;
  localparam logic [7:0] A_LER = 8'h50;

  //////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int TCR_EN      = 0;
  localparam int TCR_RST     = 1;
  localparam int TCR_PWM     = 3;
  localparam int IR_CAP_LSB  = 4;
  localparam int IR_MR4_LSB  = 8;
  localparam int EMR_EMC_LSB = 4;
  localparam int PCR_SEL_LSB = 0;
  localparam int PCR_ENA_LSB = 8;

  //////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [10:0] RST_IR   = 11'h000;
  localparam logic [3:0]  RST_TCR  = 4'h0;
  localparam logic [20:0] RST_MCR  = 21'h00_0000;
  localparam logic [11:0] RST_CCR  = 12'h000;
  localparam logic [11:0] RST_EMR  = 12'h000;
  localparam logic [13:0] RST_PCR  = 14'h0000;
  localparam logic [6:0]  RST_LER  = 7'h00;

  //////////////////////////////////////////////////////////////////////////
  // External match actions
  localparam logic [1:0] EMC_NONE = 2'b00;
  localparam logic [1:0] EMC_LOW  = 2'b01;
  localparam logic [1:0] EMC_HIGH = 2'b10;
  localparam logic [1:0] EMC_TOG  = 2'b11;

  // Per match channel control: interrupt, reset, stop
  typedef struct packed {
    logic stop;
    logic rst;
    logic irq;
  } tpw_mact_s;

  // Per capture channel control: interrupt, falling, rising
  typedef struct packed {
    logic irq;
    logic fall;
    logic rise;
  } tpw_cact_s;

endpackage : tpw_pkg

// file: rtl/tpw_top.sv
// Purpose: Timer with prescaler, match, capture and pulse width outputs
// Assumes: APB slave with zero wait states; capture inputs synchronous
// Notes:   Match values are shadowed; in pulse mode they load on release at cycle end
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps

module tpw_top
  import tpw_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Capture inputs
  input  wire logic [NCAP-1:0]   cap_in,
  // Pins and status
  output logic [NPWM-1:0]        pwm_out,
  output logic [NEM-1:0]         mat_out,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [10:0]       ir_reg;
  logic [3:0]        tcr_reg;
  logic [31:0]       tc_reg;
  logic [31:0]       pr_reg;
  logic [31:0]       pc_reg;
  logic [20:0]       mcr_reg;
  logic [11:0]       ccr_reg;
  logic [11:0]       emr_reg;
  logic [13:0]       pcr_reg;
  logic [6:0]        ler_reg;
  logic [31:0]       mr_sh_reg [NMR];
  logic [31:0]       mr_reg    [NMR];
  logic [31:0]       cr_reg    [NCAP];
  logic [NCAP-1:0]   cap_prev_reg;
  logic              tc_new_reg;
  logic [NPWM-1:0]   pwm_q_reg;
  logic [NPWM-1:0]   pwm_next;

  // Decoded bus strobes and timer events
  logic              acc;
  logic              wr;
  logic              tick;
  logic              cyc_end;
  logic              tc_zero;
  logic [NMR-1:0]    hit;
  logic [NMR-1:0]    match;
  logic [NCAP-1:0]   cap_evt;
  logic [10:0]       ir_set;
  logic              mr_stop;
  logic              mr_rst;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Match register index for an address, NMR when not a match register
  function automatic logic [2:0] mr_index(input logic [7:0] a);
    logic [2:0] r;
    r = 3'(NMR);
    if (a >= A_MR0 && a <= A_MR3) begin
      r = 3'((a - A_MR0) >> 2);
    end else if (a >= A_MR4 && a <= A_MR6) begin
      r = 3'(((a - A_MR4) >> 2) + 8'd4);
    end
    return r;
  endfunction : mr_index

  // Match control of channel i
  function automatic tpw_mact_s mact(input logic [20:0] m, input int i);
    return tpw_mact_s'(m[3*i +: 3]);
  endfunction : mact

  // Capture control of channel i
  function automatic tpw_cact_s cact(input logic [11:0] c, input int i);
    return tpw_cact_s'(c[3*i +: 3]);
  endfunction : cact

  // Interrupt register bit for match i
  function automatic int ir_bit(input int i);
    return (i < NEM) ? i : IR_MR4_LSB + i - NEM;
  endfunction : ir_bit

  ////////////////////////////////////////////////////////////////////////////
  // APB strobes: zero wait states, access completes at the first access edge
  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Match and capture events

  // Prescale rollover; no tick while the counter is held or disabled
  assign tick = tcr_reg[TCR_EN] & ~tcr_reg[TCR_RST] & (pc_reg == pr_reg);
  // End of a pulse cycle: the count leaves the rate value
  assign cyc_end = tick & (tc_reg == mr_reg[0]) & mact(mcr_reg, 0).rst;
  assign tc_zero = (tc_reg == RST_WORD);

  always_comb begin
    ir_set  = RST_IR;
    mr_stop = 1'b0;
    mr_rst  = 1'b0;
    for (int i = 0; i < NMR; i++) begin
      hit[i] = (tc_reg == mr_reg[i]);
      // A fresh count equal to the value is one match event; values above
      // the rate are never reached, so they never act
      match[i] = tc_new_reg & hit[i];
      // In pulse mode a value of zero acts as the rate value
      if (i > 0 && tcr_reg[TCR_PWM] && mr_reg[i] == RST_WORD) begin
        match[i] = tc_new_reg & (tc_reg == mr_reg[0]);
      end
      if (match[i] && mact(mcr_reg, i).irq) begin
        ir_set[ir_bit(i)] = 1'b1;
      end
      mr_stop = mr_stop | (match[i] & mact(mcr_reg, i).stop);
      mr_rst  = mr_rst | (tick & hit[i] & mact(mcr_reg, i).rst);
    end
    for (int c = 0; c < NCAP; c++) begin
      cap_evt[c] = (cact(ccr_reg, c).rise & ~cap_prev_reg[c] & cap_in[c])
                 | (cact(ccr_reg, c).fall & cap_prev_reg[c] & ~cap_in[c]);
      if (cap_evt[c] && cact(ccr_reg, c).irq) begin
        ir_set[IR_CAP_LSB + c] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and timer counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg     <= RST_WORD;
      tc_reg     <= RST_WORD;
      tc_new_reg <= 1'b0;
    end else begin
      tc_new_reg <= 1'b0;
      if (tcr_reg[TCR_RST]) begin
        pc_reg <= RST_WORD;
        tc_reg <= RST_WORD;
      end else if (wr && paddr == A_TC) begin
        tc_reg     <= pwdata;
        tc_new_reg <= 1'b1;
      end else if (tick && !mr_stop) begin
        // Stop on match freezes both counters in the stopping clock
        pc_reg     <= RST_WORD;
        tc_new_reg <= 1'b1;
        // Reset at the end of the matching cycle gives it full length
        tc_reg     <= mr_rst ? RST_WORD : tc_reg + 32'h0000_0001;
      end else if (tcr_reg[TCR_EN] && !mr_stop) begin
        pc_reg <= pc_reg + 32'h0000_0001;
      end
      if (wr && paddr == A_PC) begin
        pc_reg <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer control: stop on match drops the enable one clock after the match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcr_reg <= RST_TCR;
    end else begin
      if (wr && paddr == A_TCR) begin
        tcr_reg <= {pwdata[TCR_PWM], 1'b0, pwdata[TCR_RST], pwdata[TCR_EN]};
      end
      if (mr_stop) begin
        tcr_reg[TCR_EN] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pr_reg  <= RST_WORD;
      mcr_reg <= RST_MCR;
      ccr_reg <= RST_CCR;
      pcr_reg <= RST_PCR;
    end else if (wr) begin
      case (paddr)
        A_PR:    pr_reg  <= pwdata;
        A_MCR:   mcr_reg <= pwdata[20:0];
        A_CCR:   ccr_reg <= pwdata[11:0];
        A_PCR:   pcr_reg <= pwdata[13:0];
        default: pr_reg  <= pr_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: write one clears, a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_reg <= RST_IR;
    end else if (wr && paddr == A_IR) begin
      ir_reg <= (ir_reg & ~pwdata[10:0]) | ir_set;
    end else begin
      ir_reg <= ir_reg | ir_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match values: shadow on write, live copy loaded on release in pulse mode, on write otherwise
  // Loading only at the cycle end keeps a half old, half new pulse away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ler_reg <= RST_LER;
      for (int i = 0; i < NMR; i++) begin
        mr_sh_reg[i] <= RST_WORD;
        mr_reg[i]    <= RST_WORD;
      end
    end else begin
      for (int i = 0; i < NMR; i++) begin
        if (wr && mr_index(paddr) == 3'(i)) begin
          mr_sh_reg[i] <= pwdata;
          if (!tcr_reg[TCR_PWM]) begin
            mr_reg[i] <= pwdata;
          end
        end
        if (tcr_reg[TCR_PWM] && cyc_end && ler_reg[i]) begin
          mr_reg[i]  <= mr_sh_reg[i];
          ler_reg[i] <= 1'b0;
        end
      end
      // A release written in the loading cycle still counts; loaded bits stay clear
      if (wr && paddr == A_LER) begin
        ler_reg <= (cyc_end && tcr_reg[TCR_PWM] ? RST_LER : ler_reg) | pwdata[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_prev_reg <= '0;
      for (int c = 0; c < NCAP; c++) begin
        cr_reg[c] <= RST_WORD;
      end
    end else begin
      cap_prev_reg <= cap_in;
      for (int c = 0; c < NCAP; c++) begin
        if (cap_evt[c]) begin
          cr_reg[c] <= tc_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External match outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emr_reg <= RST_EMR;
    end else begin
      if (wr && paddr == A_EMR) begin
        emr_reg <= pwdata[11:0];
      end
      for (int e = 0; e < NEM; e++) begin
        if (match[e]) begin
          case (emr_reg[EMR_EMC_LSB + 2*e +: 2])
            EMC_LOW:  emr_reg[e] <= 1'b0;
            EMC_HIGH: emr_reg[e] <= 1'b1;
            EMC_TOG:  emr_reg[e] <= ~emr_reg[e];
            default:  emr_reg[e] <= emr_reg[e];
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse flip-flops: set source chosen per channel, clear has priority
  always_comb begin
    for (int n = 1; n <= NPWM; n++) begin
      logic set_n;
      set_n = 1'b0;
      // Channel one sees match zero either way
      set_n = pcr_reg[PCR_SEL_LSB + n - 1] ? match[n-1] : match[0];
      if (match[n]) begin
        pwm_next[n-1] = 1'b0;
      end else if (set_n) begin
        pwm_next[n-1] = 1'b1;
      end else begin
        pwm_next[n-1] = pwm_q_reg[n-1];
      end
    end
  end

  // Pins follow the pulse state when enabled; the state advances only in pulse mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_q_reg <= '0;
      pwm_out   <= '0;
    end else begin
      if (tcr_reg[TCR_PWM]) begin
        pwm_q_reg <= pwm_next;
      end
      pwm_out <= pwm_q_reg & pcr_reg[PCR_ENA_LSB +: NPWM];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mat_out <= '0;
      irq     <= 1'b0;
    end else begin
      mat_out <= emr_reg[NEM-1:0];
      irq     <= |ir_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read path: data is captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= RST_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= RST_WORD;
      if (mr_index(paddr) != 3'(NMR)) begin
        prdata <= mr_sh_reg[mr_index(paddr)];
      end else if (paddr >= A_CR0 && paddr <= A_CR3 && paddr[1:0] == 2'b00) begin
        prdata <= cr_reg[2'((paddr - A_CR0) >> 2)];
      end else begin
        case (paddr)
          A_IR:    prdata <= {21'h00_0000, ir_reg};
          A_TCR:   prdata <= {28'h000_0000, tcr_reg};
          A_TC:    prdata <= tc_reg;
          A_PR:    prdata <= pr_reg;
          A_PC:    prdata <= pc_reg;
          A_MCR:   prdata <= {11'h000, mcr_reg};
          A_CCR:   prdata <= {20'h0_0000, ccr_reg};
          A_EMR:   prdata <= {20'h0_0000, emr_reg};
          A_PCR:   prdata <= {18'h0_0000, pcr_reg};
          A_LER:   prdata <= {25'h000_0000, ler_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end else if (acc) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule : tpw_top

// file: testbench/tpw_properties.sv
// Purpose: Port level checks for the timer pulse unit
// Assumes: Zero wait APB slave, registered outputs
// Notes:   Enable shadow is rebuilt from APB writes
`timescale 1ns/1ps
module tpw_properties
  import tpw_pkg::*;
(
  // Clock and reset
  input wire logic            pclk,
  input wire logic            presetn,
  // APB
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // Pins
  input wire logic [NPWM-1:0] pwm_out,
  input wire logic            irq
);
  logic [NPWM-1:0] ena_q;
  logic [NPWM-1:0] ena_d1;
  logic [NPWM-1:0] ena_d2;

  ////////////////////////////////////////
  // Enable shadow, delayed twice so a fresh disable may drain the pin flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ena_d2, ena_d1, ena_q} <= '0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == A_PCR) begin
        ena_q <= pwdata[PCR_ENA_LSB +: NPWM];
      end
      ena_d1 <= ena_q;
      ena_d2 <= ena_d1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  // Bus answers
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_only: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == '0)
    else $error("refused read returned data");
  a_unmapped_err: assert property (psel && !penable && paddr > A_LER |=> pslverr)
    else $error("unmapped address not refused");
  a_mapped_ok: assert property (
    psel && !penable && paddr <= A_LER && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped address refused");
  a_rdata_hold: assert property (!pready |-> $stable(prdata))
    else $error("read data moved outside access");
  a_quiet_start: assert property ($rose(presetn) |-> pwm_out == '0 && !irq && !pready)
    else $error("outputs active at first edge");
  // Cheap check of the hold window: pins must stay low while disabled
  a_pwm_gated: assert property ((pwm_out & ~(ena_q | ena_d1 | ena_d2)) == '0)
    else $error("disabled pulse pin driven");
endmodule : tpw_properties

bind tpw_top tpw_properties u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .pwm_out, .irq
);

// file: testbench/tpw_top_test.sv
// Purpose: Register level tests for the timer pulse unit
// Assumes: Zero wait APB slave, one idle cycle between transfers
// Notes:   Pulse counts span whole periods, so phase does not matter
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tpw_top_test
  import tpw_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  cap_in;
  logic [5:0]  pwm_out;
  logic [3:0]  mat_out;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          fail_count;
  int          n_tests;
  int          cnt [6];
  localparam logic [3:0] EMC_EXP = 4'b0101;
  logic [7:0]  raddr [16] = '{A_IR, A_TCR, A_TC, A_PR, A_PC, A_MCR, A_MR0, A_MR3,
                              A_CCR, A_CR0, A_CR3, A_EMR, A_MR4, A_MR6, A_PCR, A_LER};
  logic [7:0]  maddr [6] = '{8'h1C, 8'h20, A_MR3, A_MR4, 8'h44, A_MR6};
  logic [31:0] mval [6] = '{32'h0000_0003, 32'h0000_0000, 32'h0000_0014,
                            32'h0000_0005, 32'h0000_0008, 32'h0000_0002};

  tpw_top u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cap_in, .pwm_out, .mat_out, .irq
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  ////////////////////////////////////////
  // One APB transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask : rdc

  // High clocks per channel over a window
  task automatic pulses(input int e [6]);
    cnt = '{default: 0};
    repeat (30) @(posedge pclk);
    repeat (30) begin
      @(posedge pclk);
      for (int i = 0; i < 6; i++) cnt[i] += int'(pwm_out[i]);
    end
    for (int i = 0; i < 6; i++) `CHK(cnt[i], e[i])
  endtask : pulses

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #5_000_000;
    fail_count++;
    summarize();
  end

  ////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cap_in} = '0;
    presetn    = 1'b0;
    fail_count = 0;
    n_tests    = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (raddr[i]) rdc(raddr[i], 32'h0000_0000);
    wr(8'h54, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
    rdc(8'h54, 32'h0000_0000);
    // Stop on match with prescale 2, match at 20
    wr(A_PR, 32'h0000_0002);
    rdc(A_PR, 32'h0000_0002);
    wr(A_MR0, 32'h0000_0014);
    wr(A_MCR, 32'h0000_0005);
    wr(A_TCR, 32'h0000_0001);
    repeat (100) @(posedge pclk);
    rdc(A_TCR, 32'h0000_0000);
    rdc(A_TC, 32'h0000_0014);
    rdc(A_IR, 32'h0000_0001);
    `CHK(irq, 1'b1)
    wr(A_IR, 32'h0000_0001);
    rdc(A_IR, 32'h0000_0000);
    `CHK(irq, 1'b0)
    // Every match output action, timer stopping at 3
    wr(A_PR, 32'h0000_0000);
    wr(A_MR0, 32'h0000_0003);
    wr(A_MCR, 32'h0000_0004);
    for (int c = 0; c < 4; c++) begin
      wr(A_EMR, {26'h000_0000, c[1:0], 3'h0, 1'(c != 2)});
      wr(A_TC, 32'h0000_0000);
      wr(A_TCR, 32'h0000_0001);
      repeat (20) @(posedge pclk);
      xfer(1'b0, A_EMR, 32'h0000_0000);
      `CHK(rd[0], EMC_EXP[c])
      `CHK(mat_out[0], EMC_EXP[c])
    end
    // Capture on rise of input 0 only, timer stopped at 0x55
    wr(A_TC, 32'h0000_0055);
    wr(A_CCR, 32'h0000_0005);
    cap_in <= 4'b0011;
    repeat (5) @(posedge pclk);
    rdc(A_CR0, 32'h0000_0055);
    rdc(8'h30, 32'h0000_0000);
    rdc(A_IR, 32'h0000_0010);
    `CHK(irq, 1'b1)
    wr(A_IR, 32'h0000_0010);
    // Pulse mode: period 10, mix of single and double edge channels
    wr(A_TCR, 32'h0000_0002);
    wr(A_MCR, 32'h0000_0002);
    wr(A_MR0, 32'h0000_0009);
    foreach (maddr[i]) wr(maddr[i], mval[i]);
    wr(A_PCR, 32'h0000_3730);
    wr(A_TCR, 32'h0000_0009);
    pulses('{12, 0, 30, 0, 9, 12});
    // New width is held back until released
    wr(8'h1C, 32'h0000_0006);
    rdc(8'h1C, 32'h0000_0006);
    pulses('{12, 0, 30, 0, 9, 12});
    wr(A_PCR, 32'h0000_3731);
    wr(A_LER, 32'h0000_0002);
    pulses('{21, 0, 30, 0, 9, 12});
    summarize();
  end
endmodule : tpw_top_test
